// file: hw/msc_regs.sv
// top of the start-up configuration bank: a classic wishbone slave holding
// the two start-up registers plus a forward set, and a latched profile output
// for the start-up controller; assumes bus and control share i_clock.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module msc_regs (
  input  wire logic                        i_clock,        // 40 MHz clock
  input  wire logic                        i_rst_n,        // async reset, active low
  input  wire logic                        i_wb_cyc,       // wishbone cycle
  input  wire logic                        i_wb_stb,       // wishbone strobe
  input  wire logic                        i_wb_we,        // write enable
  input  wire logic [3:0]                  i_wb_sel,       // byte lanes
  input  wire logic [msc_pkg::ADDR_W-1:0]  i_wb_adr,       // byte address
  input  wire logic [31:0]                 i_wb_dat,       // write data
  input  wire logic                        i_reverse_drive,// reverse drive in use
  input  wire logic                        i_decel,        // motor decelerating
  output logic      [31:0]                 o_wb_dat,       // read data
  output logic                             o_wb_ack,       // acknowledge
  output logic                             o_wb_err,       // unmapped access
  output logic                             o_brake_active, // active brake command
  output logic                             o_start_busy,   // start request pending
  output msc_pkg::msc_profile_t            o_profile       // latched start profile
);

  msc_pkg::msc_wb_req_t req;
  logic [31:0] cfg_a_q,   cfg_a_d;
  logic [31:0] cfg_b_q,   cfg_b_d;
  logic [31:0] fwd_q,     fwd_d;
  logic [31:0] rdat_q,    rdat_d;
  logic        ack_q,     ack_d;
  logic        err_q,     err_d;
  logic        start_q,   start_d;
  logic        brake_q,   brake_d;
  logic        rev_sel;
  logic [31:0] active_set;
  logic [31:0] wmask;
  logic [7:0]  idx;
  logic        aligned;
  logic        hit_a, hit_b, hit_f, hit_s;
  logic        access;
  msc_pkg::msc_profile_t prof;

  assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                 adr: i_wb_adr, dat: i_wb_dat};

  // byte address is four times the word index
  assign idx     = req.adr[msc_pkg::ADDR_W-1:2];
  assign aligned = (req.adr[1:0] == 2'h0);
  assign hit_a   = aligned && (idx == msc_pkg::REG_IDX_CFG_A);
  assign hit_b   = aligned && (idx == msc_pkg::REG_IDX_CFG_B);
  assign hit_f   = aligned && (idx == msc_pkg::REG_IDX_FWD_SET);
  assign hit_s   = aligned && (idx == msc_pkg::REG_IDX_STATUS);
  // ack drops for a cycle between requests, so a request held past its ack is taken again every other cycle
  assign access  = req.cyc && req.stb && !ack_q && !err_q;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mask
      assign wmask[8*g +: 8] = {8{req.sel[g]}};
    end
  endgenerate

  // config b is the reverse-drive set; the forward set lives alongside it
  assign rev_sel    = cfg_a_q[msc_pkg::CFG_A_REVSEL_BIT];
  assign active_set = (i_reverse_drive && rev_sel) ? cfg_b_q : fwd_q;

  always_comb begin
    cfg_a_d = cfg_a_q;
    cfg_b_d = cfg_b_q;
    fwd_d   = fwd_q;
    rdat_d  = rdat_q;
    ack_d   = 1'b0;
    err_d   = 1'b0;
    start_d = 1'b0;
    if (access) begin
      ack_d = hit_a || hit_b || hit_f || hit_s;
      err_d = !(hit_a || hit_b || hit_f || hit_s);
      if (req.we) begin
        if (hit_a) begin
          // start bit is a self-clearing strobe, never stored
          cfg_a_d = (cfg_a_q & ~wmask) | (req.dat & wmask);
          cfg_a_d[msc_pkg::CFG_A_START_BIT] = 1'b0;
          start_d = req.sel[3] && req.dat[msc_pkg::CFG_A_START_BIT];
        end
        if (hit_b) begin
          cfg_b_d = (cfg_b_q & ~wmask) | (req.dat & wmask);
        end
        if (hit_f) begin
          fwd_d = (fwd_q & ~wmask) | (req.dat & wmask);
        end
      end else begin
        rdat_d = 32'h0000_0000;
        if (hit_a) begin
          rdat_d = cfg_a_q;
        end
        if (hit_b) begin
          rdat_d = cfg_b_q;
        end
        if (hit_f) begin
          rdat_d = fwd_q;
        end
        if (hit_s) begin
          rdat_d = {30'h0000_0000, brake_q, rev_sel && i_reverse_drive};
        end
      end
    end
    brake_d = i_decel && cfg_a_q[msc_pkg::CFG_A_BRAKE_BIT];
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_a_q <= msc_pkg::CFG_A_RESET;
      cfg_b_q <= msc_pkg::CFG_B_RESET;
      fwd_q   <= msc_pkg::FWD_SET_RESET;
      rdat_q  <= 32'h0000_0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      start_q <= 1'b0;
      brake_q <= 1'b0;
    end else begin
      cfg_a_q <= cfg_a_d;
      cfg_b_q <= cfg_b_d;
      fwd_q   <= fwd_d;
      rdat_q  <= rdat_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      start_q <= start_d;
      brake_q <= brake_d;
    end
  end

  msc_decode u_decode (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_start   (start_q),
    .i_cfg_a   (cfg_a_q),
    .i_cfg_b   (active_set),
    .o_profile (prof)
  );

  assign o_wb_dat       = rdat_q;
  assign o_wb_ack       = ack_q;
  assign o_wb_err       = err_q;
  assign o_brake_active = brake_q;
  assign o_start_busy   = start_q;
  assign o_profile      = prof;

endmodule
`default_nettype wire

// file: hw/msc_pkg.sv
// holds the register map, field layout, reset values and decode tables of the
// motor start-up configuration bank; assumes a 40 MHz single clock domain.
// Notes on behaviour
// - bit 1 of config a enables active braking during deceleration; 0 disables
// - bit 0 of config a picks forward (0) or reverse (1) current and accel set for reverse drive
// - config b at offset 0x86, resets to zero, every bit including 31 read-write
// - bits 30:27 pick open-loop current cap, 0.125 A up to 8.0 A
// - bits 26:23 pick linear open-loop acceleration, 0.01 to 10000 Hz/s
// - bits 22:19 pick quadratic open-loop acceleration, 0.0 to 10000 Hz/s2
// - bit 18 set means automatic handoff; clear means handoff at speed threshold
// - bits 17:13 give handoff speed as percent of maximum, code 0 is 1%
package msc_pkg;

  // config b offset is not a multiple of four, so offsets are word indices
  localparam logic [7:0]  REG_IDX_CFG_A      = 8'h85;
  localparam logic [7:0]  REG_IDX_CFG_B      = 8'h86;
  localparam logic [7:0]  REG_IDX_FWD_SET    = 8'h87;
  localparam logic [7:0]  REG_IDX_STATUS     = 8'h88;
  localparam int          ADDR_W             = 10;

  localparam logic [31:0] CFG_A_RESET        = 32'h0000_0000;
  localparam logic [31:0] CFG_B_RESET        = 32'h0000_0000;
  localparam logic [31:0] FWD_SET_RESET      = 32'h0000_0000;

  localparam int          CFG_A_BRAKE_BIT    = 1;
  localparam int          CFG_A_REVSEL_BIT   = 0;
  localparam int          CFG_A_START_BIT    = 31;

  localparam int          CFG_B_ILIM_LSB     = 27;
  localparam int          CFG_B_ACC1_LSB     = 23;
  localparam int          CFG_B_ACC2_LSB     = 19;
  localparam int          CFG_B_AUTO_BIT     = 18;
  localparam int          CFG_B_THR_LSB      = 13;

  // current cap in mA per code
  localparam logic [15:0] ILIM_MA [16] = '{
    16'd125,  16'd250,  16'd500,  16'd1000, 16'd1500, 16'd2000, 16'd2500, 16'd3000,
    16'd3500, 16'd4000, 16'd4500, 16'd5000, 16'd5500, 16'd6000, 16'd7000, 16'd8000};

  // linear acceleration in 0.01 Hz/s units
  localparam logic [19:0] ACC1_CHZ [16] = '{
    20'd1,     20'd5,     20'd100,   20'd250,   20'd500,   20'd1000,  20'd2500,  20'd5000,
    20'd7500,  20'd10000, 20'd25000, 20'd50000, 20'd75000, 20'd100000, 20'd500000,
    20'd1000000};

  // quadratic acceleration in 0.01 Hz/s2 units
  localparam logic [19:0] ACC2_CHZ [16] = '{
    20'd0,     20'd5,     20'd100,   20'd250,   20'd500,   20'd1000,  20'd2500,  20'd5000,
    20'd7500,  20'd10000, 20'd25000, 20'd50000, 20'd75000, 20'd100000, 20'd500000,
    20'd1000000};

  // threshold in tenths of a percent of maximum speed
  localparam logic [9:0]  THR_PERMILLE [32] = '{
    10'd10,  10'd20,  10'd30,  10'd40,  10'd50,  10'd60,  10'd70,  10'd80,
    10'd90,  10'd100, 10'd110, 10'd120, 10'd130, 10'd140, 10'd150, 10'd160,
    10'd170, 10'd180, 10'd190, 10'd200, 10'd225, 10'd250, 10'd275, 10'd300,
    10'd325, 10'd330, 10'd375, 10'd400, 10'd425, 10'd450, 10'd475, 10'd500};

  typedef struct packed {
    logic        brake_enable;
    logic        auto_handoff;
    logic [15:0] current_cap_ma;
    logic [19:0] accel_linear;
    logic [19:0] accel_quadratic;
    logic [9:0]  handoff_permille;
  } msc_profile_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0]       dat;
  } msc_wb_req_t;

endpackage

// file: hw/msc_decode.sv
// decodes the packed start-up fields into physical units and latches them
// at a start event; assumes i_start is a same-clock single-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module msc_decode (
  input  wire logic                  i_clock,   // 40 MHz clock
  input  wire logic                  i_rst_n,   // async reset, active low
  input  wire logic                  i_start,   // start-up begins
  input  wire logic [31:0]           i_cfg_a,   // stored config a
  input  wire logic [31:0]           i_cfg_b,   // active set (fwd or rev)
  output msc_pkg::msc_profile_t      o_profile  // latched profile
);

  msc_pkg::msc_profile_t prof_d;
  msc_pkg::msc_profile_t prof_q;
  logic [3:0]            ilim_code;
  logic [3:0]            acc1_code;
  logic [3:0]            acc2_code;
  logic [4:0]            thr_code;

  always_comb begin
    ilim_code = i_cfg_b[msc_pkg::CFG_B_ILIM_LSB +: 4];
    acc1_code = i_cfg_b[msc_pkg::CFG_B_ACC1_LSB +: 4];
    acc2_code = i_cfg_b[msc_pkg::CFG_B_ACC2_LSB +: 4];
    thr_code  = i_cfg_b[msc_pkg::CFG_B_THR_LSB +: 5];
    prof_d    = prof_q;
    if (i_start) begin
      prof_d.brake_enable     = i_cfg_a[msc_pkg::CFG_A_BRAKE_BIT];
      prof_d.current_cap_ma   = msc_pkg::ILIM_MA[ilim_code];
      prof_d.accel_linear     = msc_pkg::ACC1_CHZ[acc1_code];
      prof_d.accel_quadratic  = msc_pkg::ACC2_CHZ[acc2_code];
      prof_d.auto_handoff     = i_cfg_b[msc_pkg::CFG_B_AUTO_BIT];
      // threshold still decoded under auto handoff; control ignores it then
      prof_d.handoff_permille = msc_pkg::THR_PERMILLE[thr_code];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prof_q <= '0;
    end else begin
      prof_q <= prof_d;
    end
  end

  assign o_profile = prof_q;

endmodule
`default_nettype wire

// file: bench/msc_regs_assertions.sv
// port checks for the start-up configuration bank
// assumes one clock domain and a classic wishbone master
`timescale 1ns/100ps
`default_nettype none
module msc_regs_assertions (
  input wire logic                  i_clock, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we,
  input wire logic [3:0]            i_wb_sel,
  input wire logic [9:0]            i_wb_adr,
  input wire logic [31:0]           i_wb_dat, o_wb_dat,
  input wire logic                  i_reverse_drive, i_decel, o_wb_ack, o_wb_err,
  input wire logic                  o_brake_active, o_start_busy,
  input wire msc_pkg::msc_profile_t o_profile
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] shadow_q;
  wire tk = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  wire mapped = i_wb_adr inside {10'h214, 10'h218, 10'h21c, 10'h220};
  // shadow of config b honours byte lanes so partial writes never false-fire
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) shadow_q <= '0;
    else if (tk && i_wb_we && i_wb_adr == 10'h218)
      for (int i = 0; i < 4; i++) if (i_wb_sel[i]) shadow_q[8*i +: 8] <= i_wb_dat[8*i +: 8];
  end
  sequence start_wr;
    tk && i_wb_we && i_wb_adr == 10'h214 && i_wb_sel[3] && i_wb_dat[31];
  endsequence
  sequence rd_b;
    tk && !i_wb_we && i_wb_adr == 10'h218;
  endsequence
  cfg_b_read_a: assert property (rd_b |=> o_wb_dat == shadow_q)
    else $error("config b read differs from last write");
  start_pulse_a: assert property (start_wr |=> o_start_busy)
    else $error("start write gave no busy pulse");
  profile_hold_a: assert property (!o_start_busy |=> $stable(o_profile))
    else $error("profile moved without a start");
  brake_off_a: assert property (!i_decel |=> !o_brake_active)
    else $error("brake active without deceleration");
  brake_cause_a: assert property ($rose(o_brake_active) |-> $past(i_decel))
    else $error("brake rose without deceleration");
  map_ack_a: assert property (tk && mapped |=> o_wb_ack && !o_wb_err)
    else $error("mapped access not acknowledged");
  unmap_err_a: assert property (tk && !mapped |=> o_wb_err && !o_wb_ack)
    else $error("unmapped access not refused");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// file: bench/msc_regs_tb.sv
// self-checking bench for the start-up configuration bank over wishbone
// assumes the bank answers each taken request after one cycle
`timescale 1ns/100ps
`default_nettype none
module msc_regs_tb;
  localparam logic [9:0] CFG_A = 10'h214, CFG_B = 10'h218, FWD = 10'h21c, STATUS = 10'h220;
  logic                  i_clock, i_rst_n, i_reverse_drive, i_decel, er;
  logic                  o_wb_ack, o_wb_err, o_brake_active, o_start_busy;
  logic [31:0]           o_wb_dat, rd;
  msc_pkg::msc_wb_req_t  rq;
  msc_pkg::msc_profile_t o_profile;
  int                    err_count, comparisons, cycles;
  msc_regs u_msc_regs (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(rq.cyc),
    .i_wb_stb(rq.stb), .i_wb_we(rq.we), .i_wb_sel(rq.sel), .i_wb_adr(rq.adr),
    .i_wb_dat(rq.dat), .i_reverse_drive(i_reverse_drive), .i_decel(i_decel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
    .o_brake_active(o_brake_active), .o_start_busy(o_start_busy), .o_profile(o_profile));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hung handshake ends here rather than stalling the run
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clock);
    rq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge i_clock); while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
    rd = o_wb_dat;
    er = o_wb_err;
    rq <= '0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask
  task automatic prof(input logic b, au, input logic [19:0] cap, lin, quad, thr);
    repeat (2) @(posedge i_clock);
    chk({31'h0, o_profile.brake_enable}, {31'h0, b}, "brake enable");
    chk({31'h0, o_profile.auto_handoff}, {31'h0, au}, "auto handoff");
    chk({16'h0, o_profile.current_cap_ma}, {12'h0, cap}, "current cap");
    chk({12'h0, o_profile.accel_linear}, {12'h0, lin}, "linear accel");
    chk({12'h0, o_profile.accel_quadratic}, {12'h0, quad}, "quadratic accel");
    chk({22'h0, o_profile.handoff_permille}, {12'h0, thr}, "threshold");
  endtask
  initial begin
    i_rst_n = 1'b0;
    rq = '0;
    i_reverse_drive = 1'b0;
    i_decel = 1'b0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rdc(CFG_B, 32'h0, "config b reset");
    rdc(CFG_A, 32'h0, "config a reset");
    bus(1'b1, CFG_B, 32'hffff_ffff);
    rdc(CFG_B, 32'hffff_ffff, "config b all ones");
    bus(1'b1, CFG_B, 32'h8000_0000);
    rdc(CFG_B, 32'h8000_0000, "reserved bit");
    bus(1'b0, 10'h300, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped refused");
    $display("test registers done");
    // reverse set: cap code 15, linear 14, quad and threshold 0; forward: cap and linear 0, quad 15, threshold 31
    i_reverse_drive <= 1'b1;
    bus(1'b1, FWD, 32'h007b_e000);
    bus(1'b1, CFG_B, 32'h7f04_0000);
    bus(1'b1, CFG_A, 32'h8000_0003);
    prof(1'b1, 1'b1, 20'd8000, 20'd500000, 20'd0, 20'd10);
    rdc(CFG_A, 32'h0000_0003, "start bit reads zero");
    rdc(FWD, 32'h007b_e000, "forward set readback");
    rdc(STATUS, 32'h0000_0001, "status reverse set active");
    i_decel <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk({31'h0, o_brake_active}, 32'h1, "brake on");
    rdc(STATUS, 32'h0000_0003, "status brake and reverse");
    bus(1'b1, CFG_A, 32'h8000_0000);
    prof(1'b0, 1'b0, 20'd125, 20'd1, 20'd1000000, 20'd500);
    chk({31'h0, o_brake_active}, 32'h0, "brake off");
    // reverse select alone must not pick the reverse set while driving forward
    i_reverse_drive <= 1'b0;
    bus(1'b1, CFG_A, 32'h8000_0001);
    prof(1'b0, 1'b0, 20'd125, 20'd1, 20'd1000000, 20'd500);
    rdc(STATUS, 32'h0000_0000, "status forward set");
    $display("test profiles done");
    // mid-run reset must bring config b back to zero after it was written
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rdc(CFG_B, 32'h0, "config b after second reset");
    rdc(CFG_A, 32'h0, "config a after second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule
bind msc_regs msc_regs_assertions u_msc_regs_assertions (.i_clock(i_clock),
  .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_sel(i_wb_sel), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .i_reverse_drive(i_reverse_drive), .i_decel(i_decel), .o_wb_ack(o_wb_ack),
  .o_wb_err(o_wb_err), .o_brake_active(o_brake_active), .o_start_busy(o_start_busy),
  .o_profile(o_profile));
`default_nettype wire
